// >>> design/hbd_cfg.svh
/*
  Register indices, field positions, reset values and the first limit code of the
  half-bridge driver control block.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef HBD_CFG_SVH
`define HBD_CFG_SVH

// register indices; byte address is four times the index
`define HBD_IDX_SWITCH_CMD   8'h01
`define HBD_IDX_CHOP_CTRL    8'h02
`define HBD_IDX_SYS_CTRL     8'h03
`define HBD_IDX_STATUS       8'h04

// switch command register: bit 2k low side, bit 2k+1 high side of leg k
`define HBD_SW_LS_OFS        0
`define HBD_SW_HS_OFS        1

// chop and limit control register
`define HBD_CTL_STAGGER_BIT  4
`define HBD_CTL_LIMIT_MSB    3
`define HBD_CTL_LIMIT_LSB    1
`define HBD_CTL_GAIN_BIT     0

// system control register
`define HBD_SYS_PSE_BIT      7
`define HBD_SYS_OTRE_BIT     6
`define HBD_SYS_DEAD_MSB     3
`define HBD_SYS_DEAD_LSB     0

// status register
`define HBD_ST_RECIRC_BIT    4
`define HBD_ST_LOW_BIT       3
`define HBD_ST_HIGH_BIT      2
`define HBD_ST_OC_BIT        1
`define HBD_ST_TEMP_BIT      0

// reset values
`define HBD_RST_SWITCH_CMD   8'h00
`define HBD_RST_LIMIT        3'h0
`define HBD_RST_DEAD         4'h4

// lowest limit code that enables limiting
`define HBD_LIMIT_FIRST_ON   3'h3

`endif

// >>> design/hbd_pkg.sv
/*
  Types shared by the half-bridge driver control modules.
  Assumes nothing of its surroundings.
*/
package hbd_pkg;
  typedef logic [7:0] hbd_reg_t;
  typedef logic [2:0] hbd_limit_t;
  typedef logic [3:0] hbd_dead_t;
  typedef enum logic [1:0] {
    HBD_LEG_OFF,
    HBD_LEG_HS,
    HBD_LEG_LS
  } hbd_leg_state_t;
endpackage

// >>> design/hbd_leg_if.sv
/*
  Link between the control top and one half-bridge leg.
  Assumes one instance per leg, joined inside the top.
*/
`timescale 1ns/100ps
`default_nettype none
interface hbd_leg_if;
  import hbd_pkg::*;
  logic      hs_allow;
  logic      ls_allow;
  logic      limit_hit;
  logic      rearm;
  hbd_dead_t dead;
  logic      hs_gate;
  logic      ls_gate;
  logic      cut;
  modport ctl (output hs_allow, ls_allow, limit_hit, rearm, dead,
               input  hs_gate, ls_gate, cut);
  modport leg (input  hs_allow, ls_allow, limit_hit, rearm, dead,
               output hs_gate, ls_gate, cut);
endinterface // hbd_leg_if
`default_nettype wire

// >>> design/hbd_sync_edge.sv
/*
  Two-flop synchroniser for a vector of pins, with edge pulses.
  Assumes inputs asynchronous to clock; edges come from the second stage.
*/
`timescale 1ns/100ps
`default_nettype none
module hbd_sync_edge #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= d_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign q    = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule // hbd_sync_edge
`default_nettype wire

// >>> design/hbd_leg.sv
/*
  One half-bridge leg: dead-time interlock and low-side chop latch.
  Assumes allow terms already gated by enables and high-side priority.
*/
`timescale 1ns/100ps
`default_nettype none
module hbd_leg
  import hbd_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  hbd_leg_if.leg    lk
);
  hbd_leg_state_t state_q;
  hbd_dead_t      cnt_q;
  logic           cut_q;
  logic           want_ls;

  // set wins over re-arm while current stays above limit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cut_q <= 1'b0;
    end else if (lk.limit_hit) begin
      cut_q <= 1'b1;
    end else if (lk.rearm) begin
      cut_q <= 1'b0;
    end
  end

  assign want_ls = lk.ls_allow & ~cut_q;

  // a switch turns on only after both were off for the dead time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= HBD_LEG_OFF;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        HBD_LEG_OFF: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (lk.hs_allow) begin
            state_q <= HBD_LEG_HS;
          end else if (want_ls) begin
            state_q <= HBD_LEG_LS;
          end
        end
        HBD_LEG_HS: begin
          if (!lk.hs_allow) begin
            state_q <= HBD_LEG_OFF;
            cnt_q   <= lk.dead;
          end
        end
        HBD_LEG_LS: begin
          if (!want_ls) begin
            state_q <= HBD_LEG_OFF;
            cnt_q   <= lk.dead;
          end
        end
        default: begin
          state_q <= HBD_LEG_OFF;
          cnt_q   <= lk.dead;
        end
      endcase
    end
  end

  assign lk.hs_gate = (state_q == HBD_LEG_HS);
  assign lk.ls_gate = (state_q == HBD_LEG_LS);
  assign lk.cut     = cut_q;
endmodule // hbd_leg
`default_nettype wire

// >>> design/hbd_top.sv
/*
  Half-bridge driver control: four legs, protection flags, chop
  re-arming and an AHB-Lite register slave.
  Assumes analog comparators and detectors on plain asynchronous pins,
  a single 20 MHz clock and an AHB-Lite master of single word transfers.
*/
// The implementer's own choice: the AHB-Lite register port.
//
// Operation
// - reset clears every switch command bit, all outputs off
// - no switch is driven unless the power-stage enable is set
// - both commands set: high side on, low side kept off
// - a switch turns on only once the other is confirmed off
// - each leg has read-write low and high command bits, 1 means on
// - low side over limit turns off, command bit unchanged
// - after a limit cut the low side returns at next chop rising edge
// - staggered mode: legs 1,2 re-arm on rising, 3,4 on falling edges
// - limit codes 0 to 2 mean no limit, 3 to 7 rising limits
// - sense gain bit 1 picks the 0.5 A range, 0 the 2.5 A range
// - recirculation indicator high while any leg freewheels
// - any high-side over-current turns off all high sides, sets flag
// - any low-side over-current turns off all low sides, sets flag
// - writing 1 to the over-current flag or reset clears it
// - low or high supply flag set keeps all outputs disabled
// - supply flags clear on write 1 or reset, stay while fault persists
// - over-temperature warning flag; enabled limit resets and disables
// - reset clears staggered enable, sense gain and limit select
// - power-stage enable gates all stages and resets to zero
// - writing 0 to the over-current flag has no effect
`timescale 1ns/100ps
`default_nettype none
`include "hbd_cfg.svh"
module hbd_top
  import hbd_pkg::*;
#(
  parameter int        LEGS      = 4,
  parameter hbd_dead_t DEAD_INIT = `HBD_RST_DEAD
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire logic            chop_frequency_input,
  input  wire logic [LEGS-1:0] hs_overcurrent_in,
  input  wire logic [LEGS-1:0] ls_overcurrent_in,
  input  wire logic [LEGS-1:0] ls_over_limit_in,
  input  wire logic [LEGS-1:0] recirculation_in,
  input  wire logic            low_supply_in,
  input  wire logic            high_supply_in,
  input  wire logic            overtemp_warning_in,
  input  wire logic            overtemp_limit_in,
  output logic      [LEGS-1:0] hs_gate_on,
  output logic      [LEGS-1:0] ls_gate_on,
  output logic      [2:0]      current_limit_select,
  output logic                 sense_gain_select,
  output logic                 recirculation_indicator,
  output logic                 power_stage_enable,
  output logic                 overtemp_reset_request
);
  localparam int PW = 4 * LEGS + 4;

  // ---------------- pin synchronisers ----------------
  logic            chop_rise;
  logic            chop_fall;
  logic [PW-1:0]   pins_a;
  logic [PW-1:0]   pins_s;
  logic [LEGS-1:0] hs_oc_s;
  logic [LEGS-1:0] ls_oc_s;
  logic [LEGS-1:0] ls_lim_s;
  logic [LEGS-1:0] recirc_s;
  logic            low_s;
  logic            high_s;
  logic            temp_warn_s;
  logic            temp_lim_s;

  hbd_sync_edge #(.W(1)) u_chop_sync (
    .clock   (clock),
    .rst     (rst),
    .d_async (chop_frequency_input),
    .q       (),
    .rise    (chop_rise),
    .fall    (chop_fall)
  );

  assign pins_a = {hs_overcurrent_in, ls_overcurrent_in, ls_over_limit_in,
                   recirculation_in, low_supply_in, high_supply_in,
                   overtemp_warning_in, overtemp_limit_in};

  hbd_sync_edge #(.W(PW)) u_pin_sync (
    .clock   (clock),
    .rst     (rst),
    .d_async (pins_a),
    .q       (pins_s),
    .rise    (),
    .fall    ()
  );

  assign {hs_oc_s, ls_oc_s, ls_lim_s, recirc_s,
          low_s, high_s, temp_warn_s, temp_lim_s} = pins_s;

  // ---------------- AHB-Lite slave ----------------
  logic        ap_valid;
  logic        wr_pend_q;
  logic [31:0] waddr_q;
  logic [31:0] hrdata_q;

  // true when a word address selects the given register index
  function automatic logic is_reg(input logic [31:0] a,
                                  input logic [7:0]  idx);
    is_reg = (a[31:2] == {22'h000000, idx});
  endfunction

  assign ap_valid = hsel & htrans[1] & hready;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      waddr_q   <= 32'h00000000;
    end else begin
      wr_pend_q <= ap_valid & hwrite;
      if (ap_valid) begin
        waddr_q <= haddr;
      end
    end
  end

  logic wr_sw;
  logic wr_ctl;
  logic wr_sys;
  logic wr_st;

  assign wr_sw  = wr_pend_q & is_reg(waddr_q, `HBD_IDX_SWITCH_CMD);
  assign wr_ctl = wr_pend_q & is_reg(waddr_q, `HBD_IDX_CHOP_CTRL);
  assign wr_sys = wr_pend_q & is_reg(waddr_q, `HBD_IDX_SYS_CTRL);
  assign wr_st  = wr_pend_q & is_reg(waddr_q, `HBD_IDX_STATUS);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // ---------------- control registers ----------------
  hbd_reg_t   sw_cmd_q;
  logic       stagger_q;
  hbd_limit_t limit_q;
  logic       gain_q;
  logic       pse_q;
  logic       otre_q;
  hbd_dead_t  dead_q;
  logic       ot_trip;

  assign ot_trip = otre_q & temp_lim_s;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sw_cmd_q <= `HBD_RST_SWITCH_CMD;
    end else if (ot_trip) begin
      sw_cmd_q <= `HBD_RST_SWITCH_CMD;
    end else if (wr_sw) begin
      sw_cmd_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stagger_q <= 1'b0;
      limit_q   <= `HBD_RST_LIMIT;
      gain_q    <= 1'b0;
    end else if (wr_ctl) begin
      stagger_q <= hwdata[`HBD_CTL_STAGGER_BIT];
      limit_q   <= hwdata[`HBD_CTL_LIMIT_MSB:`HBD_CTL_LIMIT_LSB];
      gain_q    <= hwdata[`HBD_CTL_GAIN_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pse_q <= 1'b0;
    end else if (ot_trip) begin
      pse_q <= 1'b0;
    end else if (wr_sys) begin
      pse_q <= hwdata[`HBD_SYS_PSE_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      otre_q <= 1'b0;
      dead_q <= DEAD_INIT;
    end else if (wr_sys) begin
      otre_q <= hwdata[`HBD_SYS_OTRE_BIT];
      dead_q <= hwdata[`HBD_SYS_DEAD_MSB:`HBD_SYS_DEAD_LSB];
    end
  end

  // ---------------- protection flags ----------------
  // hardware set wins over a software clear in the same cycle
  logic hs_trip_q;
  logic ls_trip_q;
  logic low_q;
  logic high_q;
  logic temp_q;
  logic clr_oc;
  logic clr_low;
  logic clr_high;
  logic clr_temp;

  assign clr_oc   = wr_st & hwdata[`HBD_ST_OC_BIT];
  assign clr_low  = wr_st & hwdata[`HBD_ST_LOW_BIT];
  assign clr_high = wr_st & hwdata[`HBD_ST_HIGH_BIT];
  assign clr_temp = wr_st & hwdata[`HBD_ST_TEMP_BIT];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hs_trip_q <= 1'b0;
      ls_trip_q <= 1'b0;
    end else begin
      hs_trip_q <= (|hs_oc_s) | (hs_trip_q & ~clr_oc);
      ls_trip_q <= (|ls_oc_s) | (ls_trip_q & ~clr_oc);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_q <= 1'b0;
    end else begin
      low_q <= low_s | (low_q & ~clr_low);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      high_q <= 1'b0;
    end else begin
      high_q <= high_s | (high_q & ~clr_high);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      temp_q <= 1'b0;
    end else begin
      temp_q <= temp_warn_s | (temp_q & ~clr_temp);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overtemp_reset_request <= 1'b0;
    end else begin
      overtemp_reset_request <= ot_trip;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      recirculation_indicator <= 1'b0;
    end else begin
      recirculation_indicator <= |recirc_s;
    end
  end

  // ---------------- leg control ----------------
  logic enable;
  logic limit_on;

  assign enable   = pse_q & ~low_q & ~high_q & ~ot_trip;
  assign limit_on = (limit_q >= `HBD_LIMIT_FIRST_ON);

  hbd_leg_if leg_if [LEGS] ();

  for (genvar g = 0; g < LEGS; g++) begin : g_leg
    logic cmd_hs;
    logic cmd_ls;

    assign cmd_hs = sw_cmd_q[2 * g + `HBD_SW_HS_OFS];
    assign cmd_ls = sw_cmd_q[2 * g + `HBD_SW_LS_OFS];

    assign leg_if[g].hs_allow  = cmd_hs & enable & ~hs_trip_q;
    assign leg_if[g].ls_allow  = cmd_ls & ~cmd_hs & enable
                                 & ~ls_trip_q;
    assign leg_if[g].limit_hit = limit_on & ls_lim_s[g];
    assign leg_if[g].rearm     = (stagger_q && g >= LEGS / 2)
                                 ? chop_fall : chop_rise;
    assign leg_if[g].dead      = dead_q;

    hbd_leg u_leg (
      .clock (clock),
      .rst   (rst),
      .lk    (leg_if[g])
    );

    assign hs_gate_on[g] = leg_if[g].hs_gate;
    assign ls_gate_on[g] = leg_if[g].ls_gate;
  end

  assign current_limit_select = limit_q;
  assign sense_gain_select    = gain_q;
  assign power_stage_enable   = pse_q;

  // ---------------- read path ----------------
  function automatic hbd_reg_t read_reg(input logic [31:0] a);
    hbd_reg_t v;
    v = 8'h00;
    if (is_reg(a, `HBD_IDX_SWITCH_CMD)) begin
      v = sw_cmd_q;
    end else if (is_reg(a, `HBD_IDX_CHOP_CTRL)) begin
      v[`HBD_CTL_STAGGER_BIT]                    = stagger_q;
      v[`HBD_CTL_LIMIT_MSB:`HBD_CTL_LIMIT_LSB]   = limit_q;
      v[`HBD_CTL_GAIN_BIT]                       = gain_q;
    end else if (is_reg(a, `HBD_IDX_SYS_CTRL)) begin
      v[`HBD_SYS_PSE_BIT]                        = pse_q;
      v[`HBD_SYS_OTRE_BIT]                       = otre_q;
      v[`HBD_SYS_DEAD_MSB:`HBD_SYS_DEAD_LSB]     = dead_q;
    end else if (is_reg(a, `HBD_IDX_STATUS)) begin
      v[`HBD_ST_RECIRC_BIT] = recirculation_indicator;
      v[`HBD_ST_LOW_BIT]    = low_q;
      v[`HBD_ST_HIGH_BIT]   = high_q;
      v[`HBD_ST_OC_BIT]     = hs_trip_q | ls_trip_q;
      v[`HBD_ST_TEMP_BIT]   = temp_q;
    end
    read_reg = v;
  endfunction

  // read data is latched at the address phase and held for the data phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata_q <= 32'h00000000;
    end else if (ap_valid && !hwrite) begin
      hrdata_q <= {24'h000000, read_reg(haddr)};
    end
  end

endmodule // hbd_top
`default_nettype wire

// >>> dv/hbd_top_chk.sv
/*
  Pin-level assertions for the half-bridge control top.
  Assumes binding into hbd_top, one clock, rst async and active high.
*/
`timescale 1ns/100ps
`default_nettype none
module hbd_top_chk #(
  parameter int LEGS = 4
) (
  input wire logic            clock,
  input wire logic            rst,
  input wire logic [LEGS-1:0] hs_overcurrent_in,
  input wire logic [LEGS-1:0] ls_overcurrent_in,
  input wire logic [LEGS-1:0] recirculation_in,
  input wire logic            low_supply_in,
  input wire logic            high_supply_in,
  input wire logic [LEGS-1:0] hs_gate_on,
  input wire logic [LEGS-1:0] ls_gate_on,
  input wire logic            recirculation_indicator,
  input wire logic            power_stage_enable,
  input wire logic            overtemp_reset_request
);
  logic [LEGS-1:0] gates;
  assign gates = hs_gate_on | ls_gate_on;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_leg_overlap: assert property ((hs_gate_on & ls_gate_on) == '0)
    else $error("both switches of a leg on");
  chk_break_gap: assert property (((hs_gate_on & $past(ls_gate_on)) |
    (ls_gate_on & $past(hs_gate_on))) == '0)
    else $error("switch on right after its partner");
  chk_enable_gate: assert property ((!power_stage_enable) [*2]
    |-> gates == '0)
    else $error("gate on while power stage disabled");
  chk_hs_trip: assert property (|hs_overcurrent_in
    |-> ##[1:5] hs_gate_on == '0)
    else $error("high sides not cut after over-current");
  chk_ls_trip: assert property (|ls_overcurrent_in
    |-> ##[1:5] ls_gate_on == '0)
    else $error("low sides not cut after over-current");
  chk_supply_cut: assert property (low_supply_in || high_supply_in
    |-> ##[1:5] gates == '0)
    else $error("gates on during supply fault");
  chk_recirc_high: assert property ((|recirculation_in) [*5]
    |-> recirculation_indicator)
    else $error("recirculation indicator low");
  chk_recirc_low: assert property ((recirculation_in == '0) [*5]
    |-> !recirculation_indicator)
    else $error("recirculation indicator high");
  chk_temp_cut: assert property (overtemp_reset_request
    |-> ##[0:3] !power_stage_enable && gates == '0)
    else $error("outputs alive during temperature reset");
endmodule // hbd_top_chk

bind hbd_top hbd_top_chk #(.LEGS(LEGS)) hbd_top_chk_inst (
  .clock(clock), .rst(rst), .hs_overcurrent_in(hs_overcurrent_in),
  .ls_overcurrent_in(ls_overcurrent_in),
  .recirculation_in(recirculation_in), .low_supply_in(low_supply_in),
  .high_supply_in(high_supply_in), .hs_gate_on(hs_gate_on),
  .ls_gate_on(ls_gate_on),
  .recirculation_indicator(recirculation_indicator),
  .power_stage_enable(power_stage_enable),
  .overtemp_reset_request(overtemp_reset_request));
`default_nettype wire

// >>> dv/hbd_chop_model.sv
/*
  Chop frequency source standing in for the controller's PWM timer.
  Assumes HALF clock cycles per half period; holds its level when idle.
*/
`timescale 1ns/100ps
`default_nettype none
module hbd_chop_model #(
  parameter int HALF = 500
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic run,
  output logic      chop
);
  int cnt_q;
  // 500 cycles of 50 ns per half period gives 20 kHz
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
      chop  <= 1'b0;
    end else if (run) begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HALF - 1) chop <= ~chop;
    end
  end
endmodule // hbd_chop_model
`default_nettype wire

// >>> dv/hbd_top_bench.sv
/*
  Self-checking bench of the half-bridge control top.
  Assumes the design package and header, the chop model and the checker.
*/
`timescale 1ns/100ps
`default_nettype none
`include "hbd_cfg.svh"
module hbd_top_bench
  import hbd_pkg::*;
;
  localparam logic [7:0] SW = `HBD_IDX_SWITCH_CMD;
  localparam logic [7:0] CT = `HBD_IDX_CHOP_CTRL;
  localparam logic [7:0] SY = `HBD_IDX_SYS_CTRL;
  localparam logic [7:0] ST = `HBD_IDX_STATUS;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        chop;
  logic        chop_run = 1'b0;
  logic [3:0]  hs_oc = 4'h0;
  logic [3:0]  ls_oc = 4'h0;
  logic [3:0]  ls_lim = 4'h0;
  logic [3:0]  recirc = 4'h0;
  logic        low_sup = 1'b0;
  logic        high_sup = 1'b0;
  logic        ot_warn = 1'b0;
  logic        ot_lim = 1'b0;
  logic [3:0]  hs_g;
  logic [3:0]  ls_g;
  logic [2:0]  lim_sel;
  logic        gain;
  logic        recirc_ind;
  logic        pse;
  logic        ot_req;
  logic [7:0]  gates;
  logic [31:0] lfsr_q = 32'ha845;
  logic [31:0] rd;
  int          n_errors = 0;
  int          samples_checked = 0;
  assign gates = {hs_g, ls_g};

  always #25 clock = ~clock;

  hbd_top #(.LEGS(4), .DEAD_INIT(4'h4)) hbd_top_inst (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .chop_frequency_input(chop), .hs_overcurrent_in(hs_oc),
    .ls_overcurrent_in(ls_oc), .ls_over_limit_in(ls_lim),
    .recirculation_in(recirc), .low_supply_in(low_sup),
    .high_supply_in(high_sup), .overtemp_warning_in(ot_warn),
    .overtemp_limit_in(ot_lim), .hs_gate_on(hs_g), .ls_gate_on(ls_g),
    .current_limit_select(lim_sel), .sense_gain_select(gain),
    .recirculation_indicator(recirc_ind), .power_stage_enable(pse),
    .overtemp_reset_request(ot_req));

  hbd_chop_model #(.HALF(500)) hbd_chop_model_inst (
    .clock(clock), .rst(rst), .run(chop_run), .chop(chop));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // high side wins a leg whose two command bits are both set
  function automatic logic [7:0] exp_gates(input hbd_reg_t c);
    logic [7:0] g;
    for (int k = 0; k < 4; k++) begin
      g[k+4] = c[2*k+1];
      g[k]   = c[2*k] & ~c[2*k+1];
    end
    return g;
  endfunction

  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic miss(input string m);
    n_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) miss("register read");
  endtask

  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) miss("pin level");
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic hang(input int n);
    if (n >= 3000) begin
      miss("wait limit");
      test_done();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 3000);
    hang(n);
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 3000);
    hang(n);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [31:0] exp);
    bus(1'b0, i, 32'h0);
    cmp_reg(rd, exp);
  endtask

  // leaves the bench just after chop reaches lvl from the other level
  task automatic chop_to(input logic lvl);
    int n;
    n = 0;
    while (chop === lvl && n < 3000) begin @(posedge clock); n++; end
    while (chop !== lvl && n < 3000) begin @(posedge clock); n++; end
    hang(n);
  endtask

  initial begin
    hbd_reg_t c;
    tick(10);
    rst <= 1'b0;
    chop_run <= 1'b1;
    tick(1);
    rdc(SW, 32'h0);
    rdc(CT, 32'h0);
    rdc(SY, {28'h0, `HBD_RST_DEAD});
    rdc(ST, 32'h0);
    wr(8'h05, 32'hff);
    rdc(8'h05, 32'h0);
    wr(SW, 32'h55);
    tick(8);
    cmp_pin(gates, 8'h00);
    wr(SY, 32'h84);
    for (int i = 0; i < 12; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      c = (i == 0) ? 8'hff : (i == 1) ? 8'haa : lfsr_q[7:0];
      recirc <= lfsr_q[11:8];
      wr(SW, {24'h0, c});
      tick(12);
      cmp_pin(gates, exp_gates(c));
      rdc(SW, {24'h0, c});
      rdc(ST, {27'h0, |recirc, 4'h0});
    end
    recirc <= 4'h0;
    wr(SW, 32'h11);
    for (int s = 0; s < 2; s++) begin
      c = s ? 8'h17 : 8'h14;
      wr(CT, {24'h0, c});
      tick(1);
      cmp_pin({4'h0, lim_sel, gain}, c & 8'h0f);
      chop_to(1'b1);
      ls_lim <= 4'h5;
      tick(1);
      ls_lim <= 4'h0;
      tick(8);
      cmp_pin(gates, s ? 8'h00 : 8'h05);
      rdc(SW, 32'h11);
      chop_to(1'b0);
      tick(8);
      cmp_pin(gates, s ? 8'h04 : 8'h05);
      chop_to(1'b1);
      tick(8);
      cmp_pin(gates, 8'h05);
    end
    wr(SW, 32'h26);
    tick(12);
    cmp_pin(gates, 8'h52);
    hs_oc <= 4'h4;
    tick(1);
    hs_oc <= 4'h0;
    tick(8);
    cmp_pin(gates, 8'h02);
    wr(ST, 32'h0);
    rdc(ST, 32'h2);
    wr(ST, 32'h2);
    tick(12);
    rdc(ST, 32'h0);
    cmp_pin(gates, 8'h52);
    ls_oc <= 4'h1;
    tick(1);
    ls_oc <= 4'h0;
    tick(8);
    cmp_pin(gates, 8'h50);
    wr(ST, 32'h2);
    tick(12);
    cmp_pin(gates, 8'h52);
    low_sup <= 1'b1;
    tick(8);
    cmp_pin(gates, 8'h00);
    wr(ST, 32'h8);
    rdc(ST, 32'h8);
    low_sup <= 1'b0;
    high_sup <= 1'b1;
    tick(8);
    wr(ST, 32'h8);
    rdc(ST, 32'h4);
    high_sup <= 1'b0;
    tick(4);
    wr(ST, 32'h4);
    tick(12);
    cmp_pin(gates, 8'h52);
    ot_warn <= 1'b1;
    tick(4);
    ot_warn <= 1'b0;
    tick(4);
    rdc(ST, 32'h1);
    wr(SY, 32'hc4);
    ot_lim <= 1'b1;
    tick(8);
    cmp_pin({ot_req, pse, 6'h0}, 8'h80);
    cmp_pin(gates, 8'h00);
    rdc(SW, 32'h0);
    ot_lim <= 1'b0;
    tick(4);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    rdc(SY, {28'h0, `HBD_RST_DEAD});
    rdc(ST, 32'h0);
    test_done();
  end
endmodule // hbd_top_bench
`default_nettype wire
